// ===== core/aap_defs.vh
`ifndef AAP_DEFS_VH
`define AAP_DEFS_VH

// Portion select codes for a move
`define AAP_PORT_WHOLE 2'h0
`define AAP_PORT_EXT 2'h1
`define AAP_PORT_UPPER 2'h2
`define AAP_PORT_LOWER 2'h3

// Field positions inside a 36-bit accumulator
`define AAP_EXT_MSB 35
`define AAP_EXT_LSB 32
`define AAP_UPPER_MSB 31
`define AAP_UPPER_LSB 16
`define AAP_LOWER_MSB 15
`define AAP_LOWER_LSB 0

// Full-scale values of the data limiter
`define AAP_POS_FULL16 16'h7FFF
`define AAP_NEG_FULL16 16'h8000

// Full-scale values of the output limiter
`define AAP_POS_FULL36 36'h07FFFFFFF
`define AAP_NEG_FULL36 36'hF80000000

// Reset values
`define AAP_ACC_RST 36'h000000000
`define AAP_WORD_RST 16'h0000

`endif

// ===== core/aap_core.v
// Functional notes
// - Optional data limiting on moves out
// - Output limiter saturates arithmetic results
// - Whole write: upper word, extend, clear lower
// - Whole read: upper word or limited value
// - Arithmetic source gets all 36 bits
// - Extension write keeps four low bits
// - Extension read sign-extends into bits 15-4
// - Upper word read unlimited, arithmetic source
// - Upper word write leaves others alone
// - Lower word access leaves others alone
// - Parallel and bit-field moves behave identically
// - Only whole-accumulator stores and word transfers are data limited
// - Word-to-accumulator arithmetic writes sign-extended
// - Move copies word; full transfer copies bits
// - No extension on single word writes
// - Limiting yields full scale, source unchanged
// - Limiting sets a latched flag
`timescale 1ns/100ps
`include "aap_defs.vh"

module aap_core (
	// Clock and reset
	input wire CLOCK,
	input wire RSTN,
	// Move request from the data bus side
	input wire MV_VALID,
	input wire MV_WRITE,
	input wire MV_ACC,
	input wire [1:0] MV_PORTION,
	input wire [15:0] MV_WDATA,
	// Data limiter enable for whole reads and word transfers
	input wire DL_EN,
	// Accumulator to accumulator transfer
	input wire XFER_VALID,
	input wire XFER_DST,
	input wire XFER_FULL,
	// Arithmetic result from the multiply-accumulate unit
	input wire MAC_VALID,
	input wire MAC_DST,
	input wire [35:0] MAC_RESULT,
	input wire MAC_LIMIT_EN,
	// Limit flag clear
	input wire LIMIT_CLR,
	// Read answer onto the data bus
	output wire [15:0] MV_RDATA,
	output wire MV_RVALID,
	// Accumulators toward the multiply-accumulate unit
	output wire [35:0] ACC_A,
	output wire [35:0] ACC_B,
	// Latched limit flag
	output wire LIMIT_FLAG
);

	// Extension holds significant bits
	function ext_used;
		input [35:0] acc;
		begin
			ext_used = ~((&acc[35:31]) | ~(|acc[35:31]));
		end
	endfunction

	// Full-scale word chosen by sign
	function [15:0] full16;
		input [35:0] acc;
		begin
			full16 = acc[`AAP_EXT_MSB] ? `AAP_NEG_FULL16 : `AAP_POS_FULL16;
		end
	endfunction

	// Word loaded into a whole accumulator
	function [35:0] word_to_acc;
		input [15:0] w;
		begin
			word_to_acc = {{4{w[15]}}, w, 16'h0000};
		end
	endfunction

	// Accumulator storage views, index 0 is A, 1 is B
	wire [35:0] acc_q [0:1];
	// Read answer registers
	reg [15:0] rdata_q;
	reg rvalid_q;
	// Sticky limit flag
	reg limit_q;

	// Selected move source
	wire [35:0] mv_src;
	// Transfer source is the other accumulator
	wire [35:0] xf_src;
	// Limiting events of this cycle
	wire mv_lim;
	wire xf_lim;
	wire mac_lim;
	// Limited transfer word
	wire [15:0] xf_word;
	// Output limiter result
	wire [35:0] mac_val;
	// Read word for the bus
	reg [15:0] rd_d;

	assign mv_src = acc_q[MV_ACC];
	assign xf_src = acc_q[~XFER_DST];

	// Move limiting applies to whole reads only; transfer and arithmetic limiting have their own terms
	assign mv_lim = MV_VALID & ~MV_WRITE & (MV_PORTION == `AAP_PORT_WHOLE)
		& DL_EN & ext_used(mv_src);
	assign xf_lim = XFER_VALID & ~XFER_FULL & DL_EN & ext_used(xf_src);
	assign mac_lim = MAC_VALID & MAC_LIMIT_EN & ext_used(MAC_RESULT);

	// Transfer word, limited when the extension is in use
	assign xf_word = xf_lim ? full16(xf_src) : xf_src[`AAP_UPPER_MSB:`AAP_UPPER_LSB];

	// Output limiter saturates to the 32-bit range
	assign mac_val = mac_lim ? (MAC_RESULT[35] ? `AAP_NEG_FULL36 : `AAP_POS_FULL36)
		: MAC_RESULT;

	// Read data selection by portion
	always @* begin
		case (MV_PORTION)
			`AAP_PORT_WHOLE: begin
				if (mv_lim) begin
					rd_d = full16(mv_src);
				end else begin
					rd_d = mv_src[`AAP_UPPER_MSB:`AAP_UPPER_LSB];
				end
			end
			`AAP_PORT_EXT: begin
				rd_d = {{12{mv_src[`AAP_EXT_MSB]}},
					mv_src[`AAP_EXT_MSB:`AAP_EXT_LSB]};
			end
			`AAP_PORT_UPPER: begin
				rd_d = mv_src[`AAP_UPPER_MSB:`AAP_UPPER_LSB];
			end
			`AAP_PORT_LOWER: begin
				rd_d = mv_src[`AAP_LOWER_MSB:`AAP_LOWER_LSB];
			end
			default: begin
				rd_d = `AAP_WORD_RST;
			end
		endcase
	end

	// Per-accumulator update; arithmetic beats transfer beats move
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_acc
			wire mac_hit;
			wire xf_hit;
			wire mv_hit;
			// Storage of this accumulator, one driving process each
			reg [35:0] cell_q;
			// Index compare kept one bit wide
			assign mac_hit = MAC_VALID & (MAC_DST == (gi != 0));
			assign xf_hit = XFER_VALID & (XFER_DST == (gi != 0));
			assign mv_hit = MV_VALID & MV_WRITE & (MV_ACC == (gi != 0));
			assign acc_q[gi] = cell_q;

			// Accumulator register
			always @(posedge CLOCK or negedge RSTN) begin
				if (!RSTN) begin
					cell_q <= `AAP_ACC_RST;
				end else if (mac_hit) begin
					cell_q <= mac_val;
				end else if (xf_hit) begin
					if (XFER_FULL) begin
						cell_q <= xf_src;
					end else begin
						cell_q <= word_to_acc(xf_word);
					end
				end else if (mv_hit) begin
					// Same handling for plain, parallel and bit-field moves
					case (MV_PORTION)
						`AAP_PORT_WHOLE: begin
							cell_q <= word_to_acc(MV_WDATA);
						end
						`AAP_PORT_EXT: begin
							cell_q[`AAP_EXT_MSB:`AAP_EXT_LSB] <= MV_WDATA[3:0];
						end
						`AAP_PORT_UPPER: begin
							cell_q[`AAP_UPPER_MSB:`AAP_UPPER_LSB] <= MV_WDATA;
						end
						`AAP_PORT_LOWER: begin
							cell_q[`AAP_LOWER_MSB:`AAP_LOWER_LSB] <= MV_WDATA;
						end
						default: begin
							cell_q <= cell_q;
						end
					endcase
				end
			end
		end
	endgenerate

	// Read answer, one cycle after the request
	always @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			rdata_q <= `AAP_WORD_RST;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= MV_VALID & ~MV_WRITE;
			if (MV_VALID & ~MV_WRITE) begin
				rdata_q <= rd_d;
			end
		end
	end

	// Limit flag, a new event wins over clear
	always @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			limit_q <= 1'b0;
		end else if (mv_lim | xf_lim | mac_lim) begin
			limit_q <= 1'b1;
		end else if (LIMIT_CLR) begin
			limit_q <= 1'b0;
		end
	end

	// Outputs straight from flip-flops
	assign MV_RDATA = rdata_q;
	assign MV_RVALID = rvalid_q;
	assign ACC_A = acc_q[0];
	assign ACC_B = acc_q[1];
	assign LIMIT_FLAG = limit_q;

endmodule

// ===== test/aap_assertions.sv
`timescale 1ns/100ps
`include "aap_defs.vh"
module aap_chk(input wire CLOCK,RSTN,MV_VALID,MV_WRITE,MV_ACC,MAC_VALID,MAC_DST,
	input wire MAC_LIMIT_EN,XFER_VALID,LIMIT_CLR,LIMIT_FLAG,MV_RVALID,DL_EN,XFER_DST,XFER_FULL,
	input wire [1:0] MV_PORTION,input wire [15:0] MV_WDATA,MV_RDATA,
	input wire [35:0] MAC_RESULT,ACC_A,ACC_B);
default clocking @(posedge CLOCK);endclocking
default disable iff(!RSTN);
// Moves aimed at accumulator A
wire rd=MV_VALID&&!MV_WRITE&&!MV_ACC;
wire wr=MV_VALID&&MV_WRITE&&!MV_ACC&&!MAC_VALID&&!XFER_VALID;
// Extension in use: bits 35 to 31 not all equal
wire a_used=(ACC_A[35:31]!=5'h1F)&&(ACC_A[35:31]!=5'h00);
wire r_used=(MAC_RESULT[35:31]!=5'h1F)&&(MAC_RESULT[35:31]!=5'h00);
// Whole read of A that the data limiter must clip
sequence lim_rd_s;
	rd&&MV_PORTION==0&&DL_EN&&a_used;
endsequence
lim_rd_a:
assert property(lim_rd_s|=>LIMIT_FLAG&&
	MV_RDATA==($past(ACC_A[35])?`AAP_NEG_FULL16:`AAP_POS_FULL16))else $error("limited read");
whole_rd_a:
assert property(rd&&MV_PORTION==0&&!(DL_EN&&a_used)|=>MV_RDATA==$past(ACC_A[31:16]))
	else $error("whole read");
mac_lim_a:
assert property(MAC_VALID&&!MAC_DST&&MAC_LIMIT_EN&&r_used|=>LIMIT_FLAG&&
	ACC_A==($past(MAC_RESULT[35])?`AAP_NEG_FULL36:`AAP_POS_FULL36))else $error("mac limit");
full_xfer_a:
assert property(XFER_VALID&&!XFER_DST&&XFER_FULL&&!MAC_VALID|=>ACC_A==$past(ACC_B))
	else $error("full transfer");
rd_ans_a:assert property(MV_VALID&&!MV_WRITE|=>MV_RVALID)else $error("no answer");
whole_wr_a:
assert property(wr&&MV_PORTION==0|=>ACC_A=={{4{$past(MV_WDATA[15])}},$past(MV_WDATA),16'h0})
	else $error("whole write");
ext_wr_a:
assert property(wr&&MV_PORTION==1|=>ACC_A=={$past(MV_WDATA[3:0]),$past(ACC_A[31:0])})
	else $error("ext write");
up_wr_a:
assert property(wr&&MV_PORTION==2|=>ACC_A[31:16]==$past(MV_WDATA)&&$stable(ACC_A[35:32]))
	else $error("upper write");
lo_wr_a:
assert property(wr&&MV_PORTION==3|=>ACC_A=={$past(ACC_A[35:16]),$past(MV_WDATA)})
	else $error("lower write");
ext_rd_a:
assert property(rd&&MV_PORTION==1|=>MV_RDATA=={{12{$past(ACC_A[35])}},$past(ACC_A[35:32])})
	else $error("ext read");
up_rd_a:assert property(rd&&MV_PORTION==2|=>MV_RDATA==$past(ACC_A[31:16]))else $error("up");
mac_wr_a:
assert property(MAC_VALID&&!MAC_DST&&!MAC_LIMIT_EN|=>ACC_A==$past(MAC_RESULT))else $error("mac");
flag_hold_a:assert property(LIMIT_FLAG&&!LIMIT_CLR|=>LIMIT_FLAG)else $error("flag");
endmodule
bind aap_core aap_chk aap_chk_inst(.CLOCK(CLOCK),.RSTN(RSTN),.MV_VALID(MV_VALID),
	.MV_WRITE(MV_WRITE),.MV_ACC(MV_ACC),.MAC_VALID(MAC_VALID),.MAC_DST(MAC_DST),
	.MAC_LIMIT_EN(MAC_LIMIT_EN),.XFER_VALID(XFER_VALID),.LIMIT_CLR(LIMIT_CLR),
	.LIMIT_FLAG(LIMIT_FLAG),.MV_RVALID(MV_RVALID),.DL_EN(DL_EN),.XFER_DST(XFER_DST),
	.XFER_FULL(XFER_FULL),.MV_PORTION(MV_PORTION),.MV_WDATA(MV_WDATA),.MV_RDATA(MV_RDATA),
	.MAC_RESULT(MAC_RESULT),.ACC_A(ACC_A),.ACC_B(ACC_B));

// ===== test/aap_mac_model.sv
`timescale 1ns/100ps
module aap_mac_model(input wire clk,go,dst,input wire [35:0] a,b,
	output reg vld,dst_q,output reg [35:0] res);
	// Adds both whole accumulators; idle result keeps toggling
	always @(posedge clk) begin
		vld<=go;
		dst_q<=dst;
		res<=go?a+b:~res;
	end
endmodule

// ===== test/tb_top.sv
`timescale 1ns/100ps
`include "aap_defs.vh"
module tb_top;
reg CLOCK=0,RSTN=0,MV_VALID=0,MV_WRITE=0,MV_ACC=0,DL_EN=0,LIMIT_CLR=0,go=0,gd=0,mle=0;
reg xv=0,xd=0,xf=0;
reg [1:0] por=0;
reg [15:0] wd=0;
wire [15:0] rdat;
wire rv,lf,mv,md;
wire [35:0] ra,rb,mr;
integer n_mismatch=0,total_checks=0;
always #25 CLOCK=~CLOCK;
aap_core aap_core_inst(.CLOCK(CLOCK),.RSTN(RSTN),.MV_VALID(MV_VALID),.MV_WRITE(MV_WRITE),
	.MV_ACC(MV_ACC),.MV_PORTION(por),.MV_WDATA(wd),.DL_EN(DL_EN),.XFER_VALID(xv),
	.XFER_DST(xd),.XFER_FULL(xf),.MAC_VALID(mv),.MAC_DST(md),.MAC_RESULT(mr),
	.MAC_LIMIT_EN(mle),.LIMIT_CLR(LIMIT_CLR),.MV_RDATA(rdat),.MV_RVALID(rv),.ACC_A(ra),
	.ACC_B(rb),.LIMIT_FLAG(lf));
aap_mac_model aap_mac_model_inst(.clk(CLOCK),.go(go),.dst(gd),.a(ra),.b(rb),.vld(mv),
	.dst_q(md),.res(mr));
task chk(input [35:0] g,e);begin
	total_checks=total_checks+1;
	if(g!==e)begin
		n_mismatch=n_mismatch+1;
		$display("mismatch t=%0t got %h exp %h",$time,g,e);
	end
end endtask
task mov(input w,c,input [1:0] p,input [15:0] d);begin
	@(negedge CLOCK);MV_VALID=1;MV_WRITE=w;MV_ACC=c;por=p;wd=d;
	@(negedge CLOCK);MV_VALID=0;
end endtask
task mac(input d,l);begin
	@(negedge CLOCK);go=1;gd=d;mle=l;
	@(negedge CLOCK);go=0;
	@(negedge CLOCK);mle=0;
end endtask
task t_portions;begin
	mov(1,0,0,16'hA987);chk(ra,36'hFA9870000);
	mov(0,0,0,16'h0);chk(rdat,16'hA987);
	chk(rv,1'h1);
	mov(1,0,1,16'hABCD);chk(ra,36'hDA9870000);
	mov(0,0,1,16'h0);chk(rdat,16'hFFFD);
	DL_EN=1;mov(0,0,0,16'h0);chk(rdat,`AAP_NEG_FULL16);
	chk(lf,1'h1);
	chk(ra,36'hDA9870000);
	mov(0,0,2,16'h0);chk(rdat,16'hA987);
	mov(1,0,2,16'h1234);chk(ra,36'hD12340000);
	mov(1,0,3,16'hA987);chk(ra,36'hD1234A987);
	mov(0,0,3,16'h0);chk(rdat,16'hA987);
	$display("t_portions done");
end endtask
task t_mac;begin
	mov(1,1,0,16'h0001);chk(rb,36'h000010000);
	mac(1,0);chk(rb,36'hD1235A987);
	LIMIT_CLR=1;@(negedge CLOCK);LIMIT_CLR=0;chk(lf,1'h0);
	mac(0,1);chk(ra,`AAP_NEG_FULL36);
	chk(lf,1'h1);
	$display("t_mac done");
end endtask
task xfr(input d,f);begin
	@(negedge CLOCK);xv=1;xd=d;xf=f;
	@(negedge CLOCK);xv=0;
end endtask
task clr;begin
	@(negedge CLOCK);LIMIT_CLR=1;
	@(negedge CLOCK);LIMIT_CLR=0;
end endtask
task t_xfer;begin
	clr;xfr(0,1);chk(ra,36'hD1235A987);
	chk(lf,1'h0);
	xfr(1,0);chk(rb,36'hF80000000);
	chk(lf,1'h1);
	DL_EN=0;clr;xfr(1,0);chk(rb,36'h012350000);
	chk(lf,1'h0);
	mov(0,1,2,16'h0);chk(rdat,16'h1235);
	mac(0,0);chk(ra,36'hD246AA987);
	$display("t_xfer done");
end endtask
task end_sim;begin
	$display("checks %0d mismatches %0d",total_checks,n_mismatch);
	if(n_mismatch==0&&total_checks>0)$display("Run complete: PASS");
	else $display("Run complete: FAIL");
	$finish;
end endtask
initial begin
	repeat(5)@(negedge CLOCK);
	RSTN=1;
	t_portions;
	t_mac;
	t_xfer;
	end_sim;
end
initial begin
	#20000;
	n_mismatch=n_mismatch+1;
	end_sim;
end
endmodule
